// ### design/afh_defs.vh
// Constants for the API command frame handler
`ifndef AFH_DEFS_VH
`define AFH_DEFS_VH

// ==================================================
// Framing
`define AFH_DELIM          8'h7E
`define AFH_CSUM_GOOD      8'hFF
`define AFH_BUF_DEPTH      32
`define AFH_BUF_DEPTH_6    6'h20
`define AFH_LEN_ZERO       6'h00

// ==================================================
// Frame types
`define AFH_TYPE_IMM       8'h08
`define AFH_TYPE_QUEUE     8'h09
`define AFH_TYPE_RESP      8'h88
`define AFH_TYPE_REMOTE    8'h17

// ==================================================
// Indices into the frame data buffer (frame offset minus 3), and minimum local and remote frame lengths
`define AFH_IX_TYPE        0
`define AFH_IX_ID          1
`define AFH_IX_CMD_HI      2
`define AFH_IX_CMD_LO      3
`define AFH_IX_PARAM       4
`define AFH_IX_ADDR        2
`define AFH_IX_RSV_HI      10
`define AFH_IX_RSV_LO      11
`define AFH_IX_OPT         12
`define AFH_IX_RCMD_HI     13
`define AFH_IX_RCMD_LO     14
`define AFH_LOC_MIN        6'h04
`define AFH_REM_MIN        6'h0F

// ==================================================
// Remote request fields
`define AFH_RSV_HI         8'hFF
`define AFH_RSV_LO         8'hFE
`define AFH_OPT_APPLY_BIT  1
`define AFH_BCAST_ADDR     64'h0000_0000_0000_FFFF

// ==================================================
// Response status codes
`define AFH_ST_OK          8'h00
`define AFH_ST_ERROR       8'h01
`define AFH_ST_BAD_CMD     8'h02
`define AFH_ST_BAD_PARAM   8'h03

// ==================================================
// Command names, limits and reset values
`define AFH_CMD_RATE       16'h4244
`define AFH_CMD_FRAMING    16'h4150
`define AFH_CMD_APPLY      16'h4143
`define AFH_CMD_DISCOVER   16'h4E44
`define AFH_RATE_MAX       8'h07
`define AFH_FRAMING_MAX    8'h02
`define AFH_RATE_RST       8'h03
`define AFH_FRAMING_RST    8'h01

// ==================================================
// Response serializer
`define AFH_RSP_LEN_HI     8'h00
`define AFH_RSP_LEN_NODATA 8'h05
`define AFH_RSP_LEN_DATA   8'h06
`define AFH_RSP_LAST_NODAT 4'h8
`define AFH_RSP_LAST_DATA  4'h9

`endif

// ### design/afh_resp_tx.v
// Response frame serializer for the API command frame handler
`timescale 1ns/1ns

module afh_resp_tx (
  input  wire        clk_i,
  input  wire        reset_n_i,
  input  wire        start_i,
  input  wire [7:0]  id_i,
  input  wire [15:0] cmd_i,
  input  wire [7:0]  status_i,
  input  wire        has_data_i,
  input  wire [7:0]  data_i,
  input  wire        tx_ready_i,
  output reg  [7:0]  tx_data_o,
  output reg         tx_valid_o
);

`include "afh_defs.vh"

  reg  [3:0]  idx;
  reg  [7:0]  id;
  reg  [15:0] cmd;
  reg  [7:0]  st;
  reg         hd;
  reg  [7:0]  dat;
  reg  [7:0]  next_byte;
  wire [3:0]  nidx = idx + 4'h1;
  wire [3:0]  last = hd ? `AFH_RSP_LAST_DATA : `AFH_RSP_LAST_NODAT;
  wire [7:0]  dsum = hd ? dat : 8'h00;
  wire [7:0]  sum  = `AFH_TYPE_RESP + id + cmd[15:8] + cmd[7:0] + st + dsum;
  wire [7:0]  csum = `AFH_CSUM_GOOD - sum;

  // ==================================================
  // Byte at the next position
  always @* begin
    case (nidx)
      4'h1: next_byte = `AFH_RSP_LEN_HI;
      4'h2: next_byte = hd ? `AFH_RSP_LEN_DATA : `AFH_RSP_LEN_NODATA;
      4'h3: next_byte = `AFH_TYPE_RESP;
      4'h4: next_byte = id;
      4'h5: next_byte = cmd[15:8];
      4'h6: next_byte = cmd[7:0];
      4'h7: next_byte = st;
      4'h8: next_byte = hd ? dat : csum;
      default: next_byte = csum;
    endcase
  end

  // ==================================================
  // Holds each byte until taken
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      idx        <= 4'h0;
      id         <= 8'h00;
      cmd        <= 16'h0000;
      st         <= 8'h00;
      hd         <= 1'b0;
      dat        <= 8'h00;
      tx_data_o  <= 8'h00;
      tx_valid_o <= 1'b0;
    end else if (start_i && !tx_valid_o) begin
      idx        <= 4'h0;
      id         <= id_i;
      cmd        <= cmd_i;
      st         <= status_i;
      hd         <= has_data_i;
      dat        <= data_i;
      tx_data_o  <= `AFH_DELIM;
      tx_valid_o <= 1'b1;
    end else if (tx_valid_o && tx_ready_i) begin
      if (idx == last) begin
        tx_valid_o <= 1'b0;
      end else begin
        idx       <= nidx;
        tx_data_o <= next_byte;
      end
    end
  end

endmodule

// ### design/afh_frame_handler.v
// API command frame parser and executor
`timescale 1ns/1ns

module afh_frame_handler (
  input  wire        clk_i,
  input  wire        reset_n_i,
  input  wire [7:0]  rx_data_i,
  input  wire        rx_valid_i,
  output reg         rx_ready_o,
  input  wire        tx_ready_i,
  output wire [7:0]  tx_data_o,
  output wire        tx_valid_o,
  output reg  [7:0]  serial_rate_o,
  output reg  [7:0]  api_framing_o,
  output reg         pending_o,
  output reg         discovery_o,
  output reg         frame_error_o,
  output reg         remote_valid_o,
  output reg  [7:0]  remote_frame_id_o,
  output reg  [63:0] remote_addr_o,
  output reg         remote_broadcast_o,
  output reg         remote_apply_o,
  output reg  [15:0] remote_cmd_o,
  output reg         remote_has_param_o,
  output reg  [7:0]  remote_param_o
);

`include "afh_defs.vh"

  localparam [2:0] ST_HUNT   = 3'h0;
  localparam [2:0] ST_LEN_HI = 3'h1;
  localparam [2:0] ST_LEN_LO = 3'h2;
  localparam [2:0] ST_DATA   = 3'h3;
  localparam [2:0] ST_CSUM   = 3'h4;
  localparam [2:0] ST_EXEC   = 3'h5;
  localparam [2:0] ST_TX     = 3'h6;

  // ==================================================
  // Parameter helpers
  function known_param;
    input [15:0] c;
    begin
      known_param = (c == `AFH_CMD_RATE) || (c == `AFH_CMD_FRAMING);
    end
  endfunction

  function [7:0] param_max;
    input [15:0] c;
    begin
      param_max = (c == `AFH_CMD_RATE) ? `AFH_RATE_MAX : `AFH_FRAMING_MAX;
    end
  endfunction

  reg  [2:0]  state;
  reg  [7:0]  len_hi;
  reg  [5:0]  flen;
  reg  [5:0]  cnt;
  reg  [7:0]  sum;
  reg  [7:0]  fbuf [0:`AFH_BUF_DEPTH-1];
  reg  [7:0]  pend_rate;
  reg  [7:0]  pend_framing;
  reg         pend_rate_f;
  reg         pend_framing_f;
  reg         tx_start;
  reg  [7:0]  tx_id;
  reg  [15:0] tx_cmd;
  reg  [7:0]  tx_status;
  reg         tx_has_data;
  reg  [7:0]  tx_value;

  wire        take    = rx_valid_i && rx_ready_o;
  wire [7:0]  ftype   = fbuf[`AFH_IX_TYPE];
  wire [7:0]  fid     = fbuf[`AFH_IX_ID];
  wire [15:0] fcmd    = {fbuf[`AFH_IX_CMD_HI], fbuf[`AFH_IX_CMD_LO]};
  wire [5:0]  last_ix = flen - 6'h01;
  wire [7:0]  fval    = fbuf[last_ix[4:0]];
  wire [15:0] rcmd    = {fbuf[`AFH_IX_RCMD_HI], fbuf[`AFH_IX_RCMD_LO]};
  wire [15:0] new_len = {len_hi, rx_data_i};
  // Both local types share one layout
  wire        is_local  = ((ftype == `AFH_TYPE_IMM) ||
                           (ftype == `AFH_TYPE_QUEUE)) &&
                          (flen >= `AFH_LOC_MIN);
  wire        is_remote = (ftype == `AFH_TYPE_REMOTE) &&
                          (flen >= `AFH_REM_MIN) &&
                          (fbuf[`AFH_IX_RSV_HI] == `AFH_RSV_HI) &&
                          (fbuf[`AFH_IX_RSV_LO] == `AFH_RSV_LO);
  // Any bytes past the name are a value
  wire        has_param = flen > `AFH_LOC_MIN;

  // ==================================================
  // Upper value bytes must be zero for 8-bit settings
  reg         hi_nz;
  reg  [63:0] addr;
  integer     i;

  always @* begin
    hi_nz = 1'b0;
    addr  = 64'h0000_0000_0000_0000;
    for (i = `AFH_IX_PARAM; i < `AFH_BUF_DEPTH; i = i + 1) begin
      if (i + 1 < flen) begin
        hi_nz = hi_nz | (fbuf[i] != 8'h00);
      end
    end
    for (i = 0; i < 8; i = i + 1) begin
      addr = {addr[55:0], fbuf[`AFH_IX_ADDR + i]};
    end
  end

  wire val_ok = !hi_nz && (fval <= param_max(fcmd));

  // ==================================================
  // Frame data store; plain memory, no reset needed
  always @(posedge clk_i) begin
    if (take && (state == ST_DATA)) begin
      fbuf[cnt[4:0]] <= rx_data_i;
    end
  end

  // ==================================================
  // Parser and executor
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state              <= ST_HUNT;
      len_hi             <= 8'h00;
      flen               <= 6'h00;
      cnt                <= 6'h00;
      sum                <= 8'h00;
      rx_ready_o         <= 1'b1;
      serial_rate_o      <= `AFH_RATE_RST;
      api_framing_o      <= `AFH_FRAMING_RST;
      pend_rate          <= `AFH_RATE_RST;
      pend_framing       <= `AFH_FRAMING_RST;
      pend_rate_f        <= 1'b0;
      pend_framing_f     <= 1'b0;
      pending_o          <= 1'b0;
      discovery_o        <= 1'b0;
      frame_error_o      <= 1'b0;
      remote_valid_o     <= 1'b0;
      remote_frame_id_o  <= 8'h00;
      remote_addr_o      <= 64'h0000_0000_0000_0000;
      remote_broadcast_o <= 1'b0;
      remote_apply_o     <= 1'b0;
      remote_cmd_o       <= 16'h0000;
      remote_has_param_o <= 1'b0;
      remote_param_o     <= 8'h00;
      tx_start           <= 1'b0;
      tx_id              <= 8'h00;
      tx_cmd             <= 16'h0000;
      tx_status          <= `AFH_ST_OK;
      tx_has_data        <= 1'b0;
      tx_value           <= 8'h00;
    end else begin
      discovery_o    <= 1'b0;
      frame_error_o  <= 1'b0;
      remote_valid_o <= 1'b0;
      tx_start       <= 1'b0;
      pending_o      <= pend_rate_f || pend_framing_f;
      case (state)
        ST_HUNT: begin
          if (take && (rx_data_i == `AFH_DELIM)) begin
            state <= ST_LEN_HI;
          end
        end
        ST_LEN_HI: begin
          if (take) begin
            len_hi <= rx_data_i;
            state  <= ST_LEN_LO;
          end
        end
        ST_LEN_LO: begin
          // Oversize or empty frames are dropped
          if (take) begin
            if ((new_len == 16'h0000) ||
                (new_len > {10'h000, `AFH_BUF_DEPTH_6})) begin
              frame_error_o <= 1'b1;
              state         <= ST_HUNT;
            end else begin
              flen  <= new_len[5:0];
              cnt   <= `AFH_LEN_ZERO;
              sum   <= 8'h00;
              state <= ST_DATA;
            end
          end
        end
        ST_DATA: begin
          if (take) begin
            sum <= sum + rx_data_i;
            cnt <= cnt + 6'h01;
            if (cnt == last_ix) begin
              state <= ST_CSUM;
            end
          end
        end
        ST_CSUM: begin
          // Sum including checksum must be 0xFF
          if (take) begin
            if ((sum + rx_data_i) == `AFH_CSUM_GOOD) begin
              rx_ready_o <= 1'b0;
              state      <= ST_EXEC;
            end else begin
              frame_error_o <= 1'b1;
              state         <= ST_HUNT;
            end
          end
        end
        ST_EXEC: begin
          tx_id       <= fid;
          tx_cmd      <= fcmd;
          tx_has_data <= 1'b0;
          tx_value    <= 8'h00;
          tx_status   <= `AFH_ST_OK;
          state       <= ST_HUNT;
          rx_ready_o  <= 1'b1;
          if (is_local) begin
            if (ftype == `AFH_TYPE_IMM) begin
              if (pend_rate_f) serial_rate_o <= pend_rate;
              if (pend_framing_f) api_framing_o <= pend_framing;
              pend_rate_f    <= 1'b0;
              pend_framing_f <= 1'b0;
            end
            // Name read from offsets 5 and 6
            if (fcmd == `AFH_CMD_APPLY) begin
              if (has_param) begin
                tx_status <= `AFH_ST_ERROR;
              end else begin
                if (pend_rate_f) serial_rate_o <= pend_rate;
                if (pend_framing_f) api_framing_o <= pend_framing;
                pend_rate_f    <= 1'b0;
                pend_framing_f <= 1'b0;
              end
            end else if (fcmd == `AFH_CMD_DISCOVER) begin
              discovery_o <= 1'b1;
            end else if (!known_param(fcmd)) begin
              tx_status <= `AFH_ST_BAD_CMD;
            end else if (!has_param) begin
              // Query returns live value at once
              tx_has_data <= 1'b1;
              tx_value    <= (fcmd == `AFH_CMD_RATE) ?
                             serial_rate_o : api_framing_o;
            end else if (!val_ok) begin
              tx_status <= `AFH_ST_BAD_PARAM;
            end else if (ftype == `AFH_TYPE_QUEUE) begin
              if (fcmd == `AFH_CMD_RATE) begin
                pend_rate   <= fval;
                pend_rate_f <= 1'b1;
              end else begin
                pend_framing   <= fval;
                pend_framing_f <= 1'b1;
              end
            end else if (fcmd == `AFH_CMD_RATE) begin
              serial_rate_o <= fval;
            end else begin
              api_framing_o <= fval;
            end
            // Zero frame id gets no reply
            if (fid != 8'h00) begin
              tx_start   <= 1'b1;
              rx_ready_o <= 1'b0;
              state      <= ST_TX;
            end
          end else if (is_remote) begin
            remote_valid_o     <= 1'b1;
            remote_frame_id_o  <= fid;
            remote_addr_o      <= addr;
            remote_broadcast_o <= (addr == `AFH_BCAST_ADDR);
            // Only the apply option bit is used
            remote_apply_o     <= fbuf[`AFH_IX_OPT][`AFH_OPT_APPLY_BIT];
            remote_cmd_o       <= rcmd;
            remote_has_param_o <= flen > `AFH_REM_MIN;
            remote_param_o     <= fval;
          end
        end
        ST_TX: begin
          // Wait for the reply to leave
          if (!tx_start && !tx_valid_o) begin
            rx_ready_o <= 1'b1;
            state      <= ST_HUNT;
          end
        end
        default: begin
          rx_ready_o <= 1'b1;
          state      <= ST_HUNT;
        end
      endcase
    end
  end

  // ==================================================
  // Reply serializer
  afh_resp_tx u_tx (
    .clk_i      (clk_i),
    .reset_n_i  (reset_n_i),
    .start_i    (tx_start),
    .id_i       (tx_id),
    .cmd_i      (tx_cmd),
    .status_i   (tx_status),
    .has_data_i (tx_has_data),
    .data_i     (tx_value),
    .tx_ready_i (tx_ready_i),
    .tx_data_o  (tx_data_o),
    .tx_valid_o (tx_valid_o)
  );

endmodule

// ### sim/afh_frame_handler_sva.sv
// Port checker for the API command frame handler
`timescale 1ns/1ns

// ==========================================
// Checker
module afh_frame_handler_chk (
  input wire       clk_i,
  input wire       reset_n_i,
  input wire       rx_ready_o,
  input wire       tx_ready_i,
  input wire [7:0] tx_data_o,
  input wire       tx_valid_o,
  input wire [7:0] serial_rate_o,
  input wire [7:0] api_framing_o,
  input wire       frame_error_o,
  input wire       remote_valid_o
);
  reg  [3:0] idx;
  reg  [7:0] len;
  reg  [7:0] sum;
  wire       take = tx_valid_o && tx_ready_i;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  // Reply byte index, cleared once receive reopens
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      idx <= 4'h0;
      len <= 8'h00;
      sum <= 8'h00;
    end else if (rx_ready_o) begin
      idx <= 4'h0;
      sum <= 8'h00;
    end else if (take) begin
      idx <= idx + 4'h1;
      if (idx == 4'h2) len <= tx_data_o;
      if (idx >= 4'h3) sum <= sum + tx_data_o;
    end
  end

  property p_delim; take && idx == 4'h0 |-> tx_data_o == 8'h7E; endproperty
  property p_len_lo;
    take && idx == 4'h2 |-> tx_data_o inside {8'h05, 8'h06};
  endproperty
  property p_type; take && idx == 4'h3 |-> tx_data_o == 8'h88; endproperty
  property p_csum;
    take && idx >= 4'h3 && {4'h0, idx} == len + 8'h03
      |-> (sum + tx_data_o) == 8'hFF;
  endproperty
  property p_hold;
    tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o);
  endproperty
  property p_busy; tx_valid_o |-> !rx_ready_o; endproperty
  // Short bad frames may follow each other, so the pulse width and eight cycles without a reply count
  property p_err;
    frame_error_o |=> (!frame_error_o && !tx_valid_o) ##1 (!tx_valid_o)[*7];
  endproperty
  property p_rem; remote_valid_o |=> (!tx_valid_o)[*8]; endproperty
  property p_range; serial_rate_o <= 8'h07 && api_framing_o <= 8'h02;
  endproperty
  // The serial rate moves only on the edge that closes an accepted frame
  property p_apply; !$stable(serial_rate_o) |-> !$past(rx_ready_o);
  endproperty

  a_delim: assert property (p_delim)
    else $error("reply opens without delimiter");
  a_len_lo: assert property (p_len_lo)
    else $error("reply length byte wrong");
  a_type: assert property (p_type)
    else $error("reply type byte wrong");
  a_csum: assert property (p_csum)
    else $error("reply checksum wrong");
  a_hold: assert property (p_hold)
    else $error("reply byte moved while stalled");
  a_busy: assert property (p_busy)
    else $error("receive open during reply");
  a_err: assert property (p_err)
    else $error("bad frame pulse long or answered");
  a_rem: assert property (p_rem)
    else $error("remote request answered locally");
  a_range: assert property (p_range)
    else $error("setting out of range");
  a_apply: assert property (p_apply)
    else $error("setting changed outside a command");

  c_reply: cover property (take && idx == 4'h9);
  c_err: cover property (frame_error_o);
  c_rem: cover property (remote_valid_o);
endmodule

bind afh_frame_handler afh_frame_handler_chk afh_frame_handler_chk_inst (
  .clk_i, .reset_n_i, .rx_ready_o, .tx_ready_i, .tx_data_o, .tx_valid_o,
  .serial_rate_o, .api_framing_o, .frame_error_o, .remote_valid_o
);

// ### sim/afh_host_model.sv
// Host model: sends API frames and sinks reply bytes
`timescale 1ns/1ns

// ==========================================
// Host side
module afh_host_model (
  input  wire        clk_i,
  input  wire        rx_ready_i,
  input  wire        tx_valid_i,
  input  wire  [7:0] tx_data_i,
  output logic [7:0] rx_data_o,
  output logic       rx_valid_o,
  output logic       tx_ready_o
);
  logic [7:0] fd [0:31];
  logic [7:0] rq [$];
  int         fn = 0;
  int         hangs = 0;
  logic       stall = 1'b0;

  initial begin
    rx_data_o = 8'h00;
    rx_valid_o = 1'b0;
    tx_ready_o = 1'b1;
  end

  // Byte held until an edge that sees ready high
  task send_byte(input logic [7:0] b);
    int   n;
    logic ok;
    #1;
    rx_data_o = b;
    rx_valid_o = 1'b1;
    n = 0;
    do begin
      @(negedge clk_i);
      ok = rx_ready_i;
      @(posedge clk_i);
      n++;
    end while (!ok && n < 500);
    if (!ok) hangs++;
  endtask

  // Released line must not look like a stale byte
  task release_line();
    #1;
    rx_valid_o = 1'b0;
    rx_data_o = ~rx_data_o;
    // Idle edge keeps the next drive at the usual delay
    @(posedge clk_i);
  endtask

  // type, id, name at offsets 5 and 6
  task load_cmd(input logic [7:0] t, id, input logic [15:0] nm,
                input logic has, input logic [7:0] p);
    fd[0] = t;
    fd[1] = id;
    fd[2] = nm[15:8];
    fd[3] = nm[7:0];
    fd[4] = p;
    fn = has ? 5 : 4;
  endtask

  task send_frame(input logic bad);
    logic [7:0] s;
    int         i;
    s = 8'h00;
    send_byte(8'h7E);
    send_byte(8'h00);
    send_byte(fn[7:0]);
    for (i = 0; i < fn; i++) begin
      send_byte(fd[i]);
      s = s + fd[i];
    end
    send_byte((8'hFF - s) ^ {7'h00, bad});
    release_line();
  endtask

  // Sink stalls every other cycle when asked
  always @(posedge clk_i) begin
    #1;
    tx_ready_o <= stall ? ~tx_ready_o : 1'b1;
  end
  always @(negedge clk_i) begin
    if (tx_valid_i && tx_ready_o) rq.push_back(tx_data_i);
  end
endmodule

// ### sim/test_api_command_frame_handler.sv
// Self-checking bench for the API command frame handler
`timescale 1ns/1ns
`include "afh_defs.vh"
`define chk(g, e) begin \
  checked++; \
  if ((g) !== (e)) begin \
    failures++; \
    $display("unexpected at %0t: got %h expected %h", $time, g, e); \
  end \
end

// ==========================================
// Bench
module test_api_command_frame_handler;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  wire  [7:0]  rx_data, tx_data, serial_rate, api_framing, r_id, r_param;
  wire         rx_valid, rx_ready, tx_ready, tx_valid, pending, discovery;
  wire         frame_error, r_valid, r_bcast, r_apply, r_has;
  wire  [63:0] r_addr;
  wire  [15:0] r_cmd;
  int          failures = 0, checked = 0, errs = 0, discs = 0, rems = 0;
  int          k;
  logic [7:0]  b;
  logic [15:0] tn [0:3] = '{16'h4244, 16'h5A5A, `AFH_CMD_APPLY,
                            `AFH_CMD_DISCOVER};
  logic [7:0]  tp [0:3] = '{8'h08, 8'h01, 8'h01, 8'h00};
  logic        th [0:3] = '{1'b1, 1'b1, 1'b1, 1'b0};
  logic [7:0]  ts [0:3] = '{8'h03, 8'h02, 8'h01, 8'h00};
  logic [7:0]  rb [0:15] = '{8'h17, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00,
                             8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFE,
                             8'h02, 8'h42, 8'h44, 8'h01};

  always #50 clk = ~clk;
  always @(posedge clk) begin
    if (frame_error) errs++;
    if (discovery) discs++;
    if (r_valid) rems++;
  end

  afh_frame_handler afh_frame_handler_inst (
    .clk_i(clk), .reset_n_i(reset_n), .rx_data_i(rx_data),
    .rx_valid_i(rx_valid), .rx_ready_o(rx_ready), .tx_ready_i(tx_ready),
    .tx_data_o(tx_data), .tx_valid_o(tx_valid),
    .serial_rate_o(serial_rate), .api_framing_o(api_framing),
    .pending_o(pending), .discovery_o(discovery),
    .frame_error_o(frame_error), .remote_valid_o(r_valid),
    .remote_frame_id_o(r_id), .remote_addr_o(r_addr),
    .remote_broadcast_o(r_bcast), .remote_apply_o(r_apply),
    .remote_cmd_o(r_cmd), .remote_has_param_o(r_has),
    .remote_param_o(r_param)
  );
  afh_host_model afh_host_model_inst (
    .clk_i(clk), .rx_ready_i(rx_ready), .tx_valid_i(tx_valid),
    .tx_data_i(tx_data), .rx_data_o(rx_data), .rx_valid_o(rx_valid),
    .tx_ready_o(tx_ready)
  );

  task end_of_test();
    failures += afh_host_model_inst.hangs;
    $display("failures %0d checked %0d", failures, checked);
    if (failures == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task cmd(input logic [7:0] t, id, input logic [15:0] nm,
           input logic has, input logic [7:0] p);
    afh_host_model_inst.load_cmd(t, id, nm, has, p);
    afh_host_model_inst.send_frame(1'b0);
  endtask

  task expect_reply(input logic [7:0] id, input logic [15:0] nm,
                    input logic [7:0] st, input logic hd,
                    input logic [7:0] v);
    logic [7:0] e [0:9];
    int         n, i;
    n = hd ? 10 : 9;
    e = '{8'h7E, 8'h00, hd ? 8'h06 : 8'h05, 8'h88, id, nm[15:8], nm[7:0],
          st, v, 8'h00};
    e[n-1] = 8'hFF - (8'h88 + id + nm[15:8] + nm[7:0] + st + (hd ? v : 0));
    i = 0;
    while (afh_host_model_inst.rq.size() < n && i < 400) begin
      @(posedge clk);
      i++;
    end
    if (i == 400) begin
      failures++;
      end_of_test();
    end
    for (i = 0; i < n; i++) begin
      b = afh_host_model_inst.rq.pop_front();
      `chk(b, e[i])
    end
  endtask

  task quiet();
    repeat (60) @(posedge clk);
    `chk(afh_host_model_inst.rq.size(), 0)
  endtask

  initial begin
    repeat (10) @(posedge clk);
    #1;
    reset_n = 1'b1;
    @(posedge clk);
    `chk(serial_rate, 8'h03)
    `chk(api_framing, 8'h01)
    `chk(rx_ready, 1'b1)
    afh_host_model_inst.stall = 1'b1;
    // Junk ahead of the first frame
    afh_host_model_inst.send_byte(8'h55);
    afh_host_model_inst.send_byte(8'h13);
    cmd(8'h09, 8'h01, `AFH_CMD_RATE, 1'b1, 8'h07);
    expect_reply(8'h01, `AFH_CMD_RATE, 8'h00, 1'b0, 8'h00);
    `chk(serial_rate, 8'h03)
    `chk(pending, 1'b1)
    cmd(8'h09, 8'h02, `AFH_CMD_RATE, 1'b0, 8'h00);
    expect_reply(8'h02, `AFH_CMD_RATE, 8'h00, 1'b1, 8'h03);
    cmd(8'h08, 8'h03, `AFH_CMD_FRAMING, 1'b1, 8'h02);
    expect_reply(8'h03, `AFH_CMD_FRAMING, 8'h00, 1'b0, 8'h00);
    `chk(serial_rate, 8'h07)
    `chk(api_framing, 8'h02)
    `chk(pending, 1'b0)
    // Every status code once
    for (k = 0; k < 4; k++) begin
      cmd(8'h08, 8'h10 + k[7:0], tn[k], th[k], tp[k]);
      expect_reply(8'h10 + k[7:0], tn[k], ts[k], 1'b0, 8'h00);
    end
    `chk(discs, 1)
    `chk(serial_rate, 8'h07)
    // Silent set still takes effect
    cmd(8'h08, 8'h00, `AFH_CMD_FRAMING, 1'b1, 8'h01);
    quiet();
    `chk(api_framing, 8'h01)
    // Empty length is dropped with an error pulse
    afh_host_model_inst.send_byte(8'h7E);
    afh_host_model_inst.send_byte(8'h00);
    afh_host_model_inst.send_byte(8'h00);
    afh_host_model_inst.release_line();
    afh_host_model_inst.load_cmd(8'h08, 8'h20, `AFH_CMD_RATE, 1'b0, 8'h00);
    afh_host_model_inst.send_frame(1'b1);
    quiet();
    `chk(errs, 2)
    cmd(8'h09, 8'h21, `AFH_CMD_RATE, 1'b1, 8'h05);
    expect_reply(8'h21, `AFH_CMD_RATE, 8'h00, 1'b0, 8'h00);
    `chk(serial_rate, 8'h07)
    cmd(8'h08, 8'h22, `AFH_CMD_APPLY, 1'b0, 8'h00);
    expect_reply(8'h22, `AFH_CMD_APPLY, 8'h00, 1'b0, 8'h00);
    `chk(serial_rate, 8'h05)
    // Broadcast remote request, apply at once
    for (k = 0; k < 16; k++) afh_host_model_inst.fd[k] = rb[k];
    afh_host_model_inst.fn = 16;
    afh_host_model_inst.send_frame(1'b0);
    quiet();
    `chk(rems, 1)
    `chk(r_id, 8'h01)
    `chk(r_addr, 64'h0000_0000_0000_FFFF)
    `chk(r_bcast, 1'b1)
    `chk(r_apply, 1'b1)
    `chk(r_cmd, 16'h4244)
    `chk(r_has, 1'b1)
    `chk(r_param, 8'h01)
    `chk(serial_rate, 8'h05)
    afh_host_model_inst.fd[1] = 8'h05;
    afh_host_model_inst.fd[9] = 8'h34;
    afh_host_model_inst.fd[12] = 8'h00;
    afh_host_model_inst.fn = 15;
    afh_host_model_inst.send_frame(1'b0);
    quiet();
    `chk(rems, 2)
    `chk(r_id, 8'h05)
    `chk(r_addr, 64'h0000_0000_0000_FF34)
    `chk(r_bcast, 1'b0)
    `chk(r_apply, 1'b0)
    `chk(r_has, 1'b0)
    end_of_test();
  end
endmodule
